// ===== logic/dgp_change_detect.sv
`timescale 1ns/100ps
module dgp_change_detect #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Synchronised levels and enables
	input wire logic [WIDTH-1:0] pinLevel,
	input wire logic [WIDTH-1:0] changeEnable,
	// Port access ends the mismatch
	input wire logic portAccess,
	// Mismatch, level
	output logic mismatch
);
	typedef struct packed {
		logic [WIDTH-1:0] lastRead;
	} dgp_chg_s;

	dgp_chg_s st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (portAccess) begin
			st_nxt.lastRead = pinLevel;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign mismatch = |((pinLevel ^ st_r.lastRead) & changeEnable);
endmodule // dgp_change_detect

// ===== logic/dgp_gpio.sv
// Operation
// - Port B is eight bidirectional pins, each with a direction bit.
// - Direction bit 1 turns the pin driver off; pin is input.
// - Direction bit 0 drives the output latch onto the pin.
// - Data reads return pin levels; data writes update only the latch.
// - Writes are read-modify-write: sampled pins merged with write, stored.
// - Direction bits control drivers even on analog-selected pins.
// - Analog-selected pins read as zero digitally; analog function enabled.
// - Analog select never affects digital output drive.
// - Each port B pin has its own weak pull-up enable bit.
// - Pull-up is forced off while the pin is an output.
// - Reset sets the global pull-up disable, turning all pull-ups off.
// - Every port B pin has an interrupt-on-change enable.
// - Port A bit 0 is digital I/O, ADC, comparator or wake input.
// - Port A bit 3 is input only; never driven.
// - Port A bit 4 is I/O, timer clock input or comparator one output.
// - Port A bit 5 is I/O, ADC, slave select or comparator two output.
// - Enabled port B pins compared with last-read value; mismatches ORed.
// - Port B access ends mismatch; persisting mismatch keeps setting flag.
// - Wake enable turns on sink on A0; a falling edge on A0 raises wake event.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps
module dgp_gpio
	import dgp_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port A pins
	input wire logic [7:0] portAIn,
	output logic [7:0] portAOut,
	output logic [7:0] portAOeN,
	// Port B pins
	input wire logic [7:0] portBIn,
	output logic [7:0] portBOut,
	output logic [7:0] portBOeN,
	output logic [7:0] portBPullupOn,
	// Peripheral hookups on port A, and analog selects of ports A and B
	input wire logic comparatorOneOutEn,
	input wire logic comparatorOneOutput,
	input wire logic comparatorTwoOutEn,
	input wire logic comparatorTwoOutput,
	output logic timerZeroClockIn,
	output logic slaveSelectIn,
	output logic [7:0] analogSelectA,
	output logic [7:0] analogSelectB,
	// Wake and change events
	output logic lowPowerWakeSink,
	output logic portBChangeFlag,
	output logic lowPowerWakeFlag
);

	typedef struct packed {
		logic [7:0] paLatch;
		logic [7:0] paDir;
		logic [7:0] pbLatch;
		logic [7:0] pbDir;
		logic [7:0] anselLo;
		logic [5:0] anselHi;
		logic [7:0] pullupEn;
		logic [7:0] changeEn;
		logic [7:0] option;
		logic [7:0] powerCtl;
		logic changeFlag;
		logic wakeFlag;
		logic wakeLevelPrev;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic [7:0] paOut;
		logic [7:0] paOeN;
		logic [7:0] pbOut;
		logic [7:0] pbOeN;
		logic [7:0] pbPull;
		logic t0ck;
		logic ssel;
	} dgp_gpio_s;

	dgp_gpio_s st_r, st_nxt;

	logic [7:0] paSync;
	logic [7:0] pbSync;
	logic mismatch;
	logic pbAccess;

	// Merge byte-lane write over a base value
	function automatic logic [7:0] lane0(input logic [7:0] base, input logic [31:0] wd,
		input logic [3:0] strb);
		lane0 = strb[0] ? wd[7:0] : base;
	endfunction

	// Map port B pin to its analog select bit
	function automatic logic [7:0] pbAnalogMask(input logic [5:0] hi);
		pbAnalogMask = '0;
		for (int i = 0; i < 8; i++) begin
			if (PB_ANS_IDX[i] < 6) begin
				pbAnalogMask[i] = hi[PB_ANS_IDX[i]];
			end
		end
	endfunction

	dgp_pin_sync #(.WIDTH(8)) uSyncA (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.pinAsync(portAIn),
		.pinSync(paSync)
	);

	dgp_pin_sync #(.WIDTH(8)) uSyncB (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.pinAsync(portBIn),
		.pinSync(pbSync)
	);

	dgp_change_detect #(.WIDTH(8)) uChange (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.pinLevel(pbSync),
		.changeEnable(st_r.changeEn),
		.portAccess(pbAccess),
		.mismatch(mismatch)
	);

	wire logic apbAccess = psel && penable && !st_r.ready;
	wire logic apbWrite = apbAccess && pwrite;
	assign pbAccess = apbAccess && (paddr == OFS_PB_DATA);

	// Digital view of the pins after analog masking
	logic [7:0] paDigital;
	logic [7:0] pbDigital;
	logic [7:0] pbAnalog;
	always_comb begin
		pbAnalog = pbAnalogMask(st_r.anselHi);
		paDigital = paSync & ~st_r.anselLo;
		pbDigital = pbSync & ~pbAnalog;
	end

	// Register file, pin drive and event flags
	always_comb begin
		st_nxt = st_r;
		st_nxt.ready = apbAccess;
		st_nxt.err = 1'b0;
		if (apbAccess) begin
			st_nxt.rdata = '0;
			unique case (paddr)
				OFS_PA_DATA: begin
					st_nxt.rdata[7:0] = paDigital;
					if (pwrite) st_nxt.paLatch = lane0(paDigital, pwdata, pstrb);
				end
				OFS_PA_DIR: begin
					st_nxt.rdata[7:0] = st_r.paDir;
					if (pwrite) st_nxt.paDir = lane0(st_r.paDir, pwdata, pstrb);
				end
				OFS_PB_DATA: begin
					st_nxt.rdata[7:0] = pbDigital;
					if (pwrite) st_nxt.pbLatch = lane0(pbDigital, pwdata, pstrb);
				end
				OFS_PB_DIR: begin
					st_nxt.rdata[7:0] = st_r.pbDir;
					if (pwrite) st_nxt.pbDir = lane0(st_r.pbDir, pwdata, pstrb);
				end
				OFS_ANALOG_SELECT_LOW_LO: begin
					st_nxt.rdata[7:0] = st_r.anselLo;
					if (pwrite) st_nxt.anselLo = lane0(st_r.anselLo, pwdata, pstrb);
				end
				OFS_ANALOG_SELECT_LOW_HI: begin
					st_nxt.rdata[5:0] = st_r.anselHi;
					if (pwrite && pstrb[0]) st_nxt.anselHi = pwdata[5:0];
				end
				OFS_PB_PULLUP: begin
					st_nxt.rdata[7:0] = st_r.pullupEn;
					if (pwrite) st_nxt.pullupEn = lane0(st_r.pullupEn, pwdata, pstrb);
				end
				OFS_PB_CHG_EN: begin
					st_nxt.rdata[7:0] = st_r.changeEn;
					if (pwrite) st_nxt.changeEn = lane0(st_r.changeEn, pwdata, pstrb);
				end
				OFS_OPTION: begin
					st_nxt.rdata[7:0] = st_r.option;
					if (pwrite) st_nxt.option = lane0(st_r.option, pwdata, pstrb);
				end
				OFS_POWER_CTL: begin
					st_nxt.rdata[7:0] = st_r.powerCtl;
					if (pwrite) st_nxt.powerCtl = lane0(st_r.powerCtl, pwdata, pstrb);
				end
				OFS_STATUS: begin
					st_nxt.rdata[CHANGE_FLAG_BIT] = st_r.changeFlag;
					st_nxt.rdata[WAKE_FLAG_BIT] = st_r.wakeFlag;
					// Write one to clear; set below wins
					if (pwrite && pstrb[0]) begin
						if (pwdata[CHANGE_FLAG_BIT]) st_nxt.changeFlag = 1'b0;
						if (pwdata[WAKE_FLAG_BIT]) st_nxt.wakeFlag = 1'b0;
					end
				end
				default: begin
					// Unmapped address answers with an error
					st_nxt.err = 1'b1;
				end
			endcase
		end

		if (mismatch) st_nxt.changeFlag = 1'b1;

		// sink on A0 and falling-edge wake event
		st_nxt.wakeLevelPrev = paSync[0];
		if (st_r.powerCtl[LOW_POWER_WAKE_EN_BIT] && st_r.wakeLevelPrev && !paSync[0]) begin
			st_nxt.wakeFlag = 1'b1;
		end

		// direction rules even on analog pins
		// analog select does not gate drive
		st_nxt.paOut = st_r.paLatch;
		st_nxt.paOeN = st_r.paDir;
		st_nxt.pbOut = st_r.pbLatch;
		st_nxt.pbOeN = st_r.pbDir;
		// A3 is input only; its driver is always off
		st_nxt.paOeN[3] = 1'b1;
		if (comparatorOneOutEn) begin
			st_nxt.paOut[4] = comparatorOneOutput;
			st_nxt.paOeN[4] = 1'b0;
		end
		if (comparatorTwoOutEn) begin
			st_nxt.paOut[5] = comparatorTwoOutput;
			st_nxt.paOeN[5] = 1'b0;
		end
		st_nxt.t0ck = paSync[4];
		st_nxt.ssel = paDigital[5];

		st_nxt.pbPull = st_r.pullupEn & st_r.pbDir & ~pbAnalog
			& {8{~st_r.option[GLOBAL_PULLUP_DIS_BIT]}};
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
			st_r.paDir <= RST_DIR;
			st_r.pbDir <= RST_DIR;
			st_r.anselLo <= RST_ANALOG_SELECT_LOW_LO;
			st_r.anselHi <= RST_ANALOG_SELECT_LOW_HI;
			st_r.pullupEn <= RST_PULLUP;
			st_r.changeEn <= RST_CHG_EN;
			st_r.option <= RST_OPTION;
			st_r.powerCtl <= RST_POWER_CTL;
			st_r.paLatch <= RST_LATCH;
			st_r.pbLatch <= RST_LATCH;
			st_r.paOeN <= RST_DIR;
			st_r.pbOeN <= RST_DIR;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops
	assign prdata = st_r.rdata;
	assign pready = st_r.ready;
	assign pslverr = st_r.err;
	assign portAOut = st_r.paOut;
	assign portAOeN = st_r.paOeN;
	assign portBOut = st_r.pbOut;
	assign portBOeN = st_r.pbOeN;
	assign portBPullupOn = st_r.pbPull;
	assign timerZeroClockIn = st_r.t0ck;
	assign slaveSelectIn = st_r.ssel;
	assign analogSelectA = st_r.anselLo;
	assign analogSelectB = {2'b00, st_r.anselHi};
	assign lowPowerWakeSink = st_r.powerCtl[LOW_POWER_WAKE_EN_BIT];
	assign portBChangeFlag = st_r.changeFlag;
	assign lowPowerWakeFlag = st_r.wakeFlag;
endmodule // dgp_gpio

// ===== logic/dgp_pin_sync.sv
`timescale 1ns/100ps
module dgp_pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Asynchronous pins and the filtered result
	input wire logic [WIDTH-1:0] pinAsync,
	output logic [WIDTH-1:0] pinSync
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] stable;
	} dgp_sync_s;

	dgp_sync_s st_r, st_nxt;

	// Three stages; a change counts once stages two and three agree
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pinAsync;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.stable[i] = st_r.s3[i];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pinSync = st_r.stable;
endmodule // dgp_pin_sync

// ===== logic/dgp_pkg.sv
package dgp_pkg;

	// Register word offsets (byte addresses)
	localparam logic [7:0] OFS_PA_DATA = 8'h00;
	localparam logic [7:0] OFS_PA_DIR = 8'h04;
	localparam logic [7:0] OFS_PB_DATA = 8'h08;
	localparam logic [7:0] OFS_PB_DIR = 8'h0C;
	localparam logic [7:0] OFS_ANALOG_SELECT_LOW_LO = 8'h10;
	localparam logic [7:0] OFS_ANALOG_SELECT_LOW_HI = 8'h14;
	localparam logic [7:0] OFS_PB_PULLUP = 8'h18;
	localparam logic [7:0] OFS_PB_CHG_EN = 8'h1C;
	localparam logic [7:0] OFS_OPTION = 8'h20;
	localparam logic [7:0] OFS_POWER_CTL = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;

	// Field positions
	localparam int GLOBAL_PULLUP_DIS_BIT = 7;
	localparam int LOW_POWER_WAKE_EN_BIT = 5;
	localparam int CHANGE_FLAG_BIT = 0;
	localparam int WAKE_FLAG_BIT = 1;

	// Reset values
	localparam logic [7:0] RST_DIR = 8'hFF;
	localparam logic [7:0] RST_ANALOG_SELECT_LOW_LO = 8'hFF;
	localparam logic [5:0] RST_ANALOG_SELECT_LOW_HI = 6'h3F;
	localparam logic [7:0] RST_PULLUP = 8'hFF;
	localparam logic [7:0] RST_CHG_EN = 8'h00;
	localparam logic [7:0] RST_OPTION = 8'hFF;
	localparam logic [7:0] RST_POWER_CTL = 8'h00;
	localparam logic [7:0] RST_LATCH = 8'h00;

	// Port B analog channel map: pin -> analog select high bit (none = 6)
	localparam int PB_ANS_IDX [8] = '{6, 6, 5, 3, 1, 0, 2, 4};

endpackage

// ===== verif/dgp_board_model.sv
`timescale 1ns/100ps
// Board side of one port
module dgp_board_model (
	// Clock for the floating pattern
	input wire logic sys_clk,
	// Device drive
	input wire logic [7:0] oeN,
	input wire logic [7:0] drv,
	input wire logic [7:0] pullOn,
	// External sources
	input wire logic [7:0] extEn,
	input wire logic [7:0] extVal,
	// Resolved level
	output logic [7:0] level
);
	// A floating pin flips each cycle so a stale value never reads back
	logic [7:0] floatPat_r = 8'h55;
	always @(posedge sys_clk) begin
		floatPat_r <= ~floatPat_r;
	end
	// Device driver first, then external source, then pull-up
	assign level = (~oeN & drv) | (oeN & extEn & extVal) | (oeN & ~extEn & (pullOn | floatPat_r));
endmodule // dgp_board_model

// ===== verif/dgp_gpio_assertions.sv
`timescale 1ns/100ps
// Port-level checks beside the gpio block
module dgp_gpio_assertions
	import dgp_pkg::*;
(
	// Clock, reset and bus
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// Pins and hookups
	input wire logic [7:0] portAOut,
	input wire logic [7:0] portAOeN,
	input wire logic [7:0] portBOeN,
	input wire logic [7:0] portBPullupOn,
	input wire logic comparatorOneOutEn,
	input wire logic comparatorOneOutput,
	input wire logic [7:0] analogSelectA,
	input wire logic lowPowerWakeSink
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// Bus answers after one wait state
	a_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	// Driver enables follow a direction write two edges on
	a_dir_drive: assert property (
		psel && penable && pready && pwrite && paddr == OFS_PB_DIR
		|-> ##2 portBOeN == $past(pwdata[7:0], 2))
		else $error("port B enables wrong");
	a_a3_input: assert property (portAOeN[3])
		else $error("A3 driven");
	// Pull-up and driver never fight
	a_pullup_out: assert property ((portBPullupOn & ~portBOeN) == 8'h00)
		else $error("pull-up on output pin");
	a_pullup_reset: assert property ($rose(arst_n) |-> (portBPullupOn == 8'h00)[*4])
		else $error("pull-up on after reset");
	a_analog_zero: assert property (
		pready && !pwrite && paddr == OFS_PA_DATA
		|-> (prdata[7:0] & analogSelectA) == 8'h00 && prdata[31:8] == 24'h0)
		else $error("analog pin read nonzero");
	a_wake_sink: assert property (
		psel && penable && pready && pwrite && paddr == OFS_POWER_CTL
		|-> ##2 lowPowerWakeSink == $past(pwdata[LOW_POWER_WAKE_EN_BIT], 2))
		else $error("sink wrong");
	a_cmp_one: assert property (
		(comparatorOneOutEn && $stable(comparatorOneOutput))[*3]
		|-> portAOut[4] == comparatorOneOutput)
		else $error("A4 not comparator");
endmodule // dgp_gpio_assertions

// ===== verif/dgp_gpio_bench.sv
`timescale 1ns/100ps
module dgp_gpio_bench
	import dgp_pkg::*;
;
	logic sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [7:0] paddr = 8'h00, portAIn, portAOut, portAOeN, portBIn, portBOut, portBOeN;
	logic [7:0] portBPullupOn, analogSelectA, analogSelectB, extA = 8'hFF, extB = 8'hFF;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic comparatorOneOutEn = 0, comparatorOneOutput = 0;
	logic comparatorTwoOutEn = 0, comparatorTwoOutput = 0;
	logic timerZeroClockIn, slaveSelectIn, lowPowerWakeSink, portBChangeFlag, lowPowerWakeFlag;
	int fail_count = 0, samples_checked = 0;

	always #5 sys_clk = ~sys_clk;
	dgp_gpio uut (.*);
	dgp_board_model brdA (.sys_clk, .oeN(portAOeN), .drv(portAOut), .pullOn(8'h00),
		.extEn(8'hFF), .extVal(extA), .level(portAIn));
	dgp_board_model brdB (.sys_clk, .oeN(portBOeN), .drv(portBOut), .pullOn(portBPullupOn),
		.extEn(8'hFF), .extVal(extB), .level(portBIn));

	task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask

	// One bus transfer; the idle edge first keeps strobes from toggling twice
	// Answer is taken at the very edge where pready is seen high, then released
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		check("pready", pready, 1);
		psel <= 0;
		penable <= 0;
	endtask

	task wt(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask

	task t_regs;
		logic [7:0] ad [9] = '{OFS_PA_DIR, OFS_PB_DIR, OFS_ANALOG_SELECT_LOW_LO, OFS_ANALOG_SELECT_LOW_HI,
			OFS_PB_PULLUP, OFS_PB_CHG_EN, OFS_OPTION, OFS_POWER_CTL, OFS_PA_DATA};
		logic [7:0] ex [9] = '{8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00};
		for (int i = 0; i < 9; i++) begin
			apb(ad[i], 0, 0);
			check("reset value", rd, {24'h0, ex[i]});
		end
		check("analog B", analogSelectB, 8'h3F);
		apb(8'h2C, 1, 32'hFF);
		check("unmapped", err, 1);
		check("pullups", portBPullupOn, 8'h00);
		$display("regs done");
	endtask

	task t_drive;
		apb(OFS_PB_DATA, 1, 32'hA5);
		apb(OFS_PB_DIR, 1, 32'h0F);
		wt(2);
		check("oe", portBOeN, 8'h0F);
		check("out", portBOut & ~portBOeN, 8'hA0);
		apb(OFS_PB_DATA, 0, 0);
		check("analog rd", rd, 32'h03);
		apb(OFS_PB_DIR, 1, 32'hFF);
		$display("drive done");
	endtask

	task t_read;
		apb(OFS_ANALOG_SELECT_LOW_HI, 1, 0);
		extB <= 8'hC3;
		wt(6);
		apb(OFS_PB_DATA, 0, 0);
		check("pins", rd, 32'hC3);
		check("analog B off", analogSelectB, 8'h00);
		apb(OFS_PB_DATA, 1, 32'h3C);
		apb(OFS_PB_DATA, 0, 0);
		check("pins2", rd, 32'hC3);
		$display("read done");
	endtask

	task t_change;
		apb(OFS_PB_CHG_EN, 1, 32'h01);
		apb(OFS_PB_DATA, 0, 0);
		apb(OFS_STATUS, 1, 32'h01);
		wt(2);
		check("flag idle", portBChangeFlag, 0);
		@(posedge sys_clk);
		extB <= 8'h83;
		wt(8);
		check("flag off pin", portBChangeFlag, 0);
		@(posedge sys_clk);
		extB <= 8'h82;
		wt(8);
		check("flag set", portBChangeFlag, 1);
		apb(OFS_STATUS, 1, 32'h01);
		wt(2);
		check("flag holds", portBChangeFlag, 1);
		apb(OFS_PB_DATA, 0, 0);
		apb(OFS_STATUS, 1, 32'h01);
		wt(2);
		check("flag clear", portBChangeFlag, 0);
		$display("change done");
	endtask

	task t_pullup;
		apb(OFS_PB_PULLUP, 1, 32'h0F);
		wt(2);
		check("pull gated", portBPullupOn, 8'h00);
		apb(OFS_OPTION, 1, 32'h7F);
		apb(OFS_PB_DIR, 1, 32'hF6);
		wt(2);
		check("pull on", portBPullupOn, 8'h06);
		apb(OFS_OPTION, 1, 32'hFF);
		apb(OFS_PB_DIR, 1, 32'hFF);
		$display("pullup done");
	endtask

	task t_wake;
		apb(OFS_ANALOG_SELECT_LOW_LO, 1, 0);
		apb(OFS_POWER_CTL, 1, 32'h20);
		wt(2);
		check("sink", lowPowerWakeSink, 1);
		check("wake idle", lowPowerWakeFlag, 0);
		@(posedge sys_clk);
		extA <= 8'hFE;
		wt(8);
		check("wake", lowPowerWakeFlag, 1);
		$display("wake done");
	endtask

	task t_cmp;
		apb(OFS_PA_DIR, 1, 0);
		comparatorOneOutEn <= 1;
		comparatorOneOutput <= 1;
		comparatorTwoOutEn <= 1;
		comparatorTwoOutput <= 1;
		wt(3);
		check("A3 off", portAOeN & 8'h08, 8'h08);
		check("cmp out", portAOut[5:4], 2'b11);
		check("latch out", portAOut[2:0], 3'b000);
		wt(4);
		check("timer in", timerZeroClockIn, 1);
		check("select in", slaveSelectIn, 1);
		$display("cmp done");
	endtask

	task test_done;
		$display("checks %0d fails %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge sys_clk);
		arst_n <= 1;
		t_regs;
		t_drive;
		t_read;
		t_change;
		t_pullup;
		t_wake;
		t_cmp;
		test_done;
	end

	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#100000;
		fail_count++;
		test_done;
	end
endmodule // dgp_gpio_bench

bind dgp_gpio dgp_gpio_assertions chk (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .portAOut, .portAOeN, .portBOeN, .portBPullupOn,
	.comparatorOneOutEn, .comparatorOneOutput, .analogSelectA, .lowPowerWakeSink);
